// ### rtl/ecs_pkg.sv
package ecs_pkg;

  // Register bus geometry
  localparam int ECS_AXI_AW = 8;
  localparam logic [1:0] ECS_RESP_OKAY = 2'h0;
  localparam logic [1:0] ECS_RESP_SLVERR = 2'h2;

  // Register byte offsets
  localparam logic [7:0] ECS_OFF_CTRL = 8'h00;
  localparam logic [7:0] ECS_OFF_BASE = 8'h04;
  localparam logic [7:0] ECS_OFF_INDEX = 8'h08;
  localparam logic [7:0] ECS_OFF_DISP = 8'h0C;
  localparam logic [7:0] ECS_OFF_LINK = 8'h10;
  localparam logic [7:0] ECS_OFF_COUNT = 8'h14;
  localparam logic [7:0] ECS_OFF_PC = 8'h18;
  localparam logic [7:0] ECS_OFF_EA = 8'h1C;
  localparam logic [7:0] ECS_OFF_TARGET = 8'h20;
  localparam logic [7:0] ECS_OFF_STATUS = 8'h24;
  localparam logic [7:0] ECS_OFF_SYNC = 8'h28;
  localparam logic [7:0] ECS_OFF_LANES = 8'h2C;

  // Control register fields
  localparam int ECS_CTRL_LE = 0;
  localparam int ECS_CTRL_BHTEN = 1;
  localparam int ECS_CTRL_BRANCH_HISTORY_CLEAR_BIT = 2;
  localparam int ECS_CTRL_INDEXED = 3;
  localparam int ECS_CTRL_BASEZERO = 4;
  localparam int ECS_CTRL_BRSRC = 5;
  localparam int ECS_CTRL_BRABS = 7;
  localparam int ECS_CTRL_SIZE = 8;
  localparam logic [31:0] ECS_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] ECS_CTRL_MASK = 32'h0000_07FB;

  // Sync command fields
  localparam int ECS_SYNC_OP = 0;
  localparam int ECS_SYNC_CTX = 4;

  // Status fields
  localparam int ECS_ST_ALIGNED = 0;
  localparam int ECS_ST_MISALIGNED = 1;
  localparam int ECS_ST_WRAPS = 2;
  localparam int ECS_ST_BUSY = 3;
  localparam int ECS_ST_CTX = 4;
  localparam int ECS_ST_HIST = 8;
  localparam int ECS_ST_COUNT = 16;

  // Address arithmetic constants and reset values
  localparam logic [31:0] ECS_FETCH_STEP = 32'h0000_0004;
  localparam logic [31:0] ECS_BRANCH_MASK = 32'hFFFF_FFFC;
  localparam logic [31:0] ECS_PC_RESET = 32'h0000_0000;
  localparam logic [2:0] ECS_CTX_RESET = 3'h0;

  // Asynchronous interrupt kinds
  localparam logic [1:0] ECS_IRQ_RESET = 2'h1;
  localparam logic [1:0] ECS_IRQ_MCHECK = 2'h2;

  typedef enum logic [1:0] {ECS_OP_NONE, ECS_OP_ISYNC, ECS_OP_SC, ECS_OP_RFI} ecs_op_e;
  typedef enum logic [1:0] {ECS_BR_IMM, ECS_BR_LINK, ECS_BR_COUNT, ECS_BR_RSVD} ecs_br_e;
  typedef enum logic {ECS_SYNC_IDLE, ECS_SYNC_DRAIN} ecs_sync_e;

endpackage

// ### rtl/ecs_ea_add.sv
`timescale 1ns/10ps
module ecs_ea_add import ecs_pkg::*; (
  // Operands
  input wire logic [31:0] a,
  input wire logic [31:0] b,
  input wire logic zeroA,
  // Result
  output logic [31:0] sum,
  output logic carryOut
);

  logic [32:0] full;

  // Unsigned add; the carry is kept only for visibility, never fed back
  assign full = {1'b0, (zeroA ? 32'h0000_0000 : a)} + {1'b0, b};
  assign sum = full[31:0];
  assign carryOut = full[32];

endmodule // ecs_ea_add

// ### rtl/ecs_op_check.sv
`timescale 1ns/10ps
module ecs_op_check import ecs_pkg::*; (
  // Operand description
  input wire logic [31:0] ea,
  input wire logic [2:0] sizeLog2,
  input wire logic littleEndian,
  // Classification
  output logic aligned,
  output logic wraps,
  output logic [31:0] lastAddr,
  output logic [31:0] lsbAddr,
  output logic [31:0] msbAddr
);

  logic [31:0] lenMask;
  logic [32:0] endFull;

  // Length is a power of two, up to 128 bytes
  assign lenMask = (32'h0000_0001 << sizeLog2) - 32'h0000_0001;
  assign aligned = (ea & lenMask) == 32'h0000_0000;
  // Last byte runs past the top and continues from address zero
  assign endFull = {1'b0, ea} + {1'b0, lenMask};
  assign wraps = endFull[32];
  assign lastAddr = endFull[31:0];
  // Big endian puts the most significant byte at the operand address
  assign lsbAddr = littleEndian ? ea : lastAddr;
  assign msbAddr = littleEndian ? lastAddr : ea;

endmodule // ecs_op_check

// ### rtl/ecs_ea_gen_context_sync.sv
// Notes on behaviour
// [RULE_01] Data, branch and sequential fetch addresses are 32-bit sums.
// [RULE_02] An operand running past the top continues from address zero.
// [RULE_03] Address adds are unsigned; the carry out of the top is dropped.
// [RULE_04] Load/store address is base plus displacement or base plus index; base zero reads zero.
// [RULE_05] Branch targets come from a displacement, the link or the count register.
// [RULE_06] An operand's address is that of its lowest-numbered byte.
// [RULE_07] Big endian by default; little endian when the mode bit is set.
// [RULE_08] Aligned only when the address is a multiple of the operand length.
// [RULE_09] System call and return wait until older instructions cannot fault.
// [RULE_10] A system call is taken only with no higher priority interrupt pending.
// [RULE_11] Older instructions keep the old context; younger run in the new one.
// [RULE_12] Instruction sync, call, return and most interrupts synchronize context.
// [RULE_13] Several bits written together may use the strictest ordering needed.
// [RULE_14] Disable history, sync, set clear, branch; later branches see cleared history.
// [RULE_15] Cache enable or invalidate writes are followed at once by a context sync.
// [RULE_16] Extended addressing changes only with caches and translation off, then flush.
// [RULE_17] Instruction translation flips need the sync at both addresses.
// [RULE_18] Error disable writes need barriers before and barrier plus sync after.
// [RULE_19] Cache lock, way lock and error inject writes are bracketed by syncs.
// [RULE_20] Endian mode change on return needs stream stop and barrier first.
// [RULE_21] Power management writes need stream stop, barrier, then context sync.
// [RULE_22] Translation and subsystem register writes need barriers and sync around them.
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
module ecs_ea_gen_context_sync import ecs_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // AXI4-Lite write channels
  input wire logic [ECS_AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [ECS_AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pipeline status
  input wire logic olderCanFault,
  input wire logic directStoreOpen,
  input wire logic higherIrqPending,
  input wire logic asyncIrq,
  input wire logic [1:0] asyncIrqKind,
  input wire logic fetchAdvance,
  input wire logic branchResolved,
  input wire logic branchTaken,
  // Address results
  output logic [31:0] fetchPc,
  output logic [31:0] dataEa,
  output logic [31:0] branchTarget,
  output logic eaAligned,
  output logic eaWraps,
  // Context control
  output logic issueHold,
  output logic [2:0] issueCtx,
  output logic ctxSyncPulse,
  output logic sysCallTake,
  output logic [7:0] branchHistory
);

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] base;
    logic [31:0] index;
    logic [31:0] disp;
    logic [31:0] link;
    logic [31:0] count;
    logic [31:0] pc;
    logic [31:0] ea;
    logic [31:0] target;
    logic [31:0] lsb;
    logic [31:0] msb;
    logic aligned;
    logic wraps;
    logic [7:0] history;
    logic [2:0] ctxCur;
    logic [2:0] ctxNew;
    ecs_op_e op;
    ecs_sync_e fsm;
    logic [15:0] syncCount;
    logic ctxPulse;
    logic scPulse;
    logic awHave;
    logic [ECS_AXI_AW-1:0] awAddr;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ecs_state_s;

  ecs_state_s st;
  ecs_state_s next_st;

  logic [31:0] ldstSum;
  logic [31:0] immSum;
  logic [31:0] seqPc;
  logic [31:0] offsetSel;
  logic [31:0] brTarget;
  logic ckAligned;
  logic ckWraps;
  logic [31:0] ckLsb;
  logic [31:0] ckMsb;
  ecs_br_e brSrc;
  logic drainDone;

  // Merge byte lanes of a write into the old value
  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Load/store address: displacement or index form
  assign offsetSel = st.ctrl[ECS_CTRL_INDEXED] ? st.index : st.disp; // [RULE_04]
  ecs_ea_add ldstAdd (
    .a(st.base),
    .b(offsetSel),
    .zeroA(st.ctrl[ECS_CTRL_BASEZERO]), // [RULE_04]
    .sum(ldstSum),
    .carryOut()
  ); // [RULE_03]

  // Immediate branch target, relative or absolute
  ecs_ea_add immAdd (
    .a(st.pc),
    .b(st.disp),
    .zeroA(st.ctrl[ECS_CTRL_BRABS]),
    .sum(immSum),
    .carryOut()
  ); // [RULE_01]

  // Sequential fetch also wraps at the top of the space
  ecs_ea_add seqAdd (
    .a(st.pc),
    .b(ECS_FETCH_STEP),
    .zeroA(1'b0),
    .sum(seqPc),
    .carryOut()
  ); // [RULE_01]

  // Operand classification of the current data address
  ecs_op_check opCheck (
    .ea(ldstSum),
    .sizeLog2(st.ctrl[ECS_CTRL_SIZE +: 3]),
    .littleEndian(st.ctrl[ECS_CTRL_LE]), // [RULE_07]
    .aligned(ckAligned), // [RULE_08]
    .wraps(ckWraps), // [RULE_02]
    .lastAddr(),
    .lsbAddr(ckLsb),
    .msbAddr(ckMsb)
  ); // [RULE_06]

  // Branch target source select; link and count drop the low two bits
  assign brSrc = ecs_br_e'(st.ctrl[ECS_CTRL_BRSRC +: 2]);
  always_comb begin
    case (brSrc) // [RULE_05]
      ECS_BR_LINK: brTarget = st.link & ECS_BRANCH_MASK;
      ECS_BR_COUNT: brTarget = st.count & ECS_BRANCH_MASK;
      default: brTarget = immSum;
    endcase
  end

  // Older work must be past every fault point, and a call waits out higher interrupts
  assign drainDone = !olderCanFault && !directStoreOpen &&
                     !(st.op == ECS_OP_SC && higherIrqPending); // [RULE_09] [RULE_10]

  // Next state
  always_comb begin
    next_st = st;
    next_st.ctxPulse = 1'b0;
    next_st.scPulse = 1'b0;
    next_st.ea = ldstSum;
    next_st.target = brTarget;
    next_st.aligned = ckAligned;
    next_st.wraps = ckWraps;
    next_st.lsb = ckLsb;
    next_st.msb = ckMsb;
    // Branch history only learns while enabled
    if (branchResolved && st.ctrl[ECS_CTRL_BHTEN]) begin
      next_st.history = {st.history[6:0], branchTaken};
    end
    // Taken branch beats sequential advance
    if (branchResolved && branchTaken) begin
      next_st.pc = st.target;
    end else if (fetchAdvance && !issueHold) begin
      next_st.pc = seqPc; // [RULE_01]
    end
    // Write address and data are taken independently
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.awHave = 1'b1;
      next_st.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.wHave = 1'b1;
      next_st.wData = s_axi_wdata;
      next_st.wStrb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    // Commit a write once both halves are held
    if (st.awHave && st.wHave && !st.bvalid) begin
      next_st.awHave = 1'b0;
      next_st.wHave = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = ECS_RESP_OKAY;
      case (st.awAddr)
        ECS_OFF_CTRL: begin
          next_st.ctrl = merge_bytes(st.ctrl, st.wData, st.wStrb) & ECS_CTRL_MASK;
          // Clear is a strobe: history is wiped so every later branch sees it fresh
          if (st.wStrb[0] && st.wData[ECS_CTRL_BRANCH_HISTORY_CLEAR_BIT]) begin
            next_st.history = 8'h00; // [RULE_14]
          end
        end
        ECS_OFF_BASE: next_st.base = merge_bytes(st.base, st.wData, st.wStrb);
        ECS_OFF_INDEX: next_st.index = merge_bytes(st.index, st.wData, st.wStrb);
        ECS_OFF_DISP: next_st.disp = merge_bytes(st.disp, st.wData, st.wStrb);
        ECS_OFF_LINK: next_st.link = merge_bytes(st.link, st.wData, st.wStrb);
        ECS_OFF_COUNT: next_st.count = merge_bytes(st.count, st.wData, st.wStrb);
        ECS_OFF_PC: next_st.pc = merge_bytes(st.pc, st.wData, st.wStrb);
        ECS_OFF_SYNC: begin
          // A second sync while one drains is refused, not queued
          if (st.fsm != ECS_SYNC_IDLE || !st.wStrb[0] ||
              st.wData[ECS_SYNC_OP +: 2] == ECS_OP_NONE) begin
            next_st.bresp = ECS_RESP_SLVERR;
          end else begin
            next_st.op = ecs_op_e'(st.wData[ECS_SYNC_OP +: 2]);
            next_st.fsm = ECS_SYNC_DRAIN;
            // Instruction sync keeps the context; call and return bring a new one
            next_st.ctxNew = (st.wData[ECS_SYNC_OP +: 2] == ECS_OP_ISYNC) ?
                             st.ctxCur : st.wData[ECS_SYNC_CTX +: 3];
          end
        end
        default: next_st.bresp = ECS_RESP_SLVERR;
      endcase
    end
    // Read answer one cycle after the address is taken
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = ECS_RESP_OKAY;
      next_st.rdata = 32'h0000_0000;
      case (s_axi_araddr)
        ECS_OFF_CTRL: next_st.rdata = st.ctrl;
        ECS_OFF_BASE: next_st.rdata = st.base;
        ECS_OFF_INDEX: next_st.rdata = st.index;
        ECS_OFF_DISP: next_st.rdata = st.disp;
        ECS_OFF_LINK: next_st.rdata = st.link;
        ECS_OFF_COUNT: next_st.rdata = st.count;
        ECS_OFF_PC: next_st.rdata = st.pc;
        ECS_OFF_EA: next_st.rdata = st.ea;
        ECS_OFF_TARGET: next_st.rdata = st.target;
        ECS_OFF_LANES: next_st.rdata = {st.msb[15:0], st.lsb[15:0]};
        ECS_OFF_SYNC: next_st.rdata = {30'h0000_0000, st.op};
        ECS_OFF_STATUS: begin
          next_st.rdata[ECS_ST_ALIGNED] = st.aligned;
          next_st.rdata[ECS_ST_MISALIGNED] = !st.aligned;
          next_st.rdata[ECS_ST_WRAPS] = st.wraps;
          next_st.rdata[ECS_ST_BUSY] = st.fsm != ECS_SYNC_IDLE;
          next_st.rdata[ECS_ST_CTX +: 3] = st.ctxCur;
          next_st.rdata[ECS_ST_HIST +: 8] = st.history;
          next_st.rdata[ECS_ST_COUNT +: 16] = st.syncCount;
        end
        default: next_st.rresp = ECS_RESP_SLVERR;
      endcase
    end
    // Context switch happens only after the drain, so older work saw the old context
    case (st.fsm)
      ECS_SYNC_IDLE: begin
      end
      ECS_SYNC_DRAIN: begin
        if (drainDone) begin // [RULE_09]
          next_st.fsm = ECS_SYNC_IDLE;
          next_st.ctxCur = st.ctxNew; // [RULE_11]
          next_st.ctxPulse = 1'b1; // [RULE_12]
          next_st.scPulse = st.op == ECS_OP_SC; // [RULE_10]
          next_st.op = ECS_OP_NONE;
        end
      end
      default: next_st.fsm = ECS_SYNC_IDLE;
    endcase
    // Interrupts other than reset and machine check also synchronize context
    if (asyncIrq && asyncIrqKind != ECS_IRQ_RESET && asyncIrqKind != ECS_IRQ_MCHECK) begin
      next_st.ctxPulse = 1'b1; // [RULE_12]
    end
    if (next_st.ctxPulse) begin
      next_st.syncCount = st.syncCount + 16'h0001;
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      next_st_reset: begin
        st <= '0;
        st.ctrl <= ECS_CTRL_RESET; // [RULE_07]
        st.pc <= ECS_PC_RESET;
        st.ctxCur <= ECS_CTX_RESET;
        st.ctxNew <= ECS_CTX_RESET;
        st.op <= ECS_OP_NONE;
        st.fsm <= ECS_SYNC_IDLE;
        st.aligned <= 1'b1;
      end
    end else begin
      st <= next_st;
    end
  end

  // Ready outputs are combinational, valids and data come from flops
  assign s_axi_awready = !st.awHave && !st.bvalid;
  assign s_axi_wready = !st.wHave && !st.bvalid;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign fetchPc = st.pc;
  assign dataEa = st.ea;
  assign branchTarget = st.target;
  assign eaAligned = st.aligned;
  assign eaWraps = st.wraps;
  assign issueHold = st.fsm != ECS_SYNC_IDLE; // [RULE_11]
  assign issueCtx = st.ctxCur;
  assign ctxSyncPulse = st.ctxPulse;
  assign sysCallTake = st.scPulse;
  assign branchHistory = st.history;

  // Checks
  seq_fetch_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE_01]
    fetchAdvance && !issueHold && !branchResolved && !(st.awHave && st.wHave && !st.bvalid)
    |=> fetchPc == $past(fetchPc) + ECS_FETCH_STEP)
    else $error("sequential fetch did not step by one word");

  operand_wrap_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE_02]
    ##1 eaWraps == (({1'b0, $past(ldstSum)} +
      {1'b0, (32'h0000_0001 << $past(st.ctrl[ECS_CTRL_SIZE +: 3]))}) > 33'h1_0000_0000))
    else $error("operand wrap flag wrong");

  ldst_sum_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE_04]
    ##1 dataEa == ($past(st.ctrl[ECS_CTRL_BASEZERO]) ? 32'h0000_0000 : $past(st.base)) +
      ($past(st.ctrl[ECS_CTRL_INDEXED]) ? $past(st.index) : $past(st.disp)))
    else $error("load store address wrong");

  branch_source_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE_05]
    brSrc == ECS_BR_COUNT |=> branchTarget == ($past(st.count) & ECS_BRANCH_MASK))
    else $error("count register target wrong");

  natural_align_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE_08]
    st.ctrl[ECS_CTRL_SIZE +: 3] == 3'h2 |=> eaAligned == ($past(ldstSum[1:0]) == 2'h0))
    else $error("word alignment flag wrong");

  endian_lane_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE_07]
    !st.ctrl[ECS_CTRL_LE] |=> st.msb == dataEa)
    else $error("big endian high byte not at operand address");

  drain_wait_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE_09]
    issueHold && (olderCanFault || directStoreOpen) |=> issueHold && issueCtx == $past(issueCtx))
    else $error("sync finished while older work could fault");

  call_priority_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE_10]
    sysCallTake |-> !$past(higherIrqPending) && $past(issueHold))
    else $error("system call taken over higher interrupt");

  sync_count_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE_12]
    ctxSyncPulse |-> st.syncCount == $past(st.syncCount) + 16'h0001)
    else $error("sync event not counted");

  history_clear_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE_14]
    st.awHave && st.wHave && !st.bvalid && st.awAddr == ECS_OFF_CTRL && st.wStrb[0] &&
    st.wData[ECS_CTRL_BRANCH_HISTORY_CLEAR_BIT] |=> branchHistory == 8'h00)
    else $error("history not cleared");

  sc_taken_c: cover property (@(posedge core_clk) disable iff (rst) sysCallTake);
  wrap_seen_c: cover property (@(posedge core_clk) disable iff (rst) eaWraps && !eaAligned);
  irq_sync_c: cover property (@(posedge core_clk) disable iff (rst)
    asyncIrq && !issueHold ##1 ctxSyncPulse);

endmodule // ecs_ea_gen_context_sync

// ### verification/ecs_sw_model.sv
`timescale 1ns/10ps
module ecs_sw_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Scenario knobs
  input wire logic [3:0] drainCycles,
  input wire logic irqBusy,
  // Core view
  input wire logic issueHold,
  // Pipeline status
  output logic olderCanFault,
  output logic directStoreOpen,
  output logic higherIrqPending
);
  logic [4:0] age;

  // Software keeps its ordering duties: no data streams run, so no stream stop,
  // and only sync commands are fenced by this drain acting as barrier and sync
  // Age of the current drain; older work retires one step per cycle
  always_ff @(posedge core_clk) begin
    if (rst || !issueHold) begin
      age <= 5'h00;
    end else if (age != 5'h1F) begin
      age <= age + 5'h01;
    end
  end

  // Faults stay possible until drained; store errors resolve one cycle later
  assign olderCanFault = issueHold && (age < {1'b0, drainCycles});
  assign directStoreOpen = issueHold && (age <= {1'b0, drainCycles});
  // A higher priority interrupt clears last, so a call must wait longer
  assign higherIrqPending = irqBusy && issueHold && (age <= {1'b0, drainCycles} + 5'h01);
endmodule // ecs_sw_model

// ### verification/ecs_ea_gen_context_sync_tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module ecs_ea_gen_context_sync_tb_top import ecs_pkg::*;;
  logic core_clk = 1'b0, rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF, drainCycles = 4'h3;
  logic [1:0] asyncIrqKind = 2'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, asyncIrq = 1'b0, irqBusy = 1'b0;
  logic fetchAdvance = 1'b0, branchResolved = 1'b0, branchTaken = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, fetchPc, dataEa, branchTarget;
  logic eaAligned, eaWraps, issueHold, ctxSyncPulse, sysCallTake, seen;
  logic olderCanFault, directStoreOpen, higherIrqPending;
  logic [2:0] issueCtx;
  logic [7:0] branchHistory;
  int fail_count = 0, total_checks = 0, cycles = 0, n;

  ecs_ea_gen_context_sync i_dut (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .olderCanFault, .directStoreOpen, .higherIrqPending, .asyncIrq,
    .asyncIrqKind, .fetchAdvance, .branchResolved, .branchTaken, .fetchPc, .dataEa, .branchTarget,
    .eaAligned, .eaWraps, .issueHold, .issueCtx, .ctxSyncPulse, .sysCallTake, .branchHistory);
  ecs_sw_model i_sw (.core_clk, .rst, .drainCycles, .irqBusy, .issueHold, .olderCanFault,
    .directStoreOpen, .higherIrqPending);

  // Clock and a ceiling well above the expected run length
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge core_clk);
  endtask

  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge core_clk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    // Ready stays high between writes, so each response is accepted in the cycle it is seen
    do @(posedge core_clk); while (!s_axi_bvalid);
    `CHK("bresp", er, s_axi_bresp)
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge core_clk);
    `CHK("rresp", er, s_axi_rresp)
    `CHK("rdata", ed, s_axi_rdata)
  endtask

  task automatic branch;
    branchResolved <= 1'b1;
    branchTaken <= 1'b1;
    step(1);
    branchResolved <= 1'b0;
    step(2);
  endtask

  // Issue a sync command and wait for the context switch
  task automatic sync(input logic [1:0] op, input logic [2:0] ctx, input logic [2:0] ec);
    wr(ECS_OFF_SYNC, {25'h0, ctx, 2'b00, op}, ECS_RESP_OKAY);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (!ctxSyncPulse && n < 50);
    `CHK("pulse", 1'b1, ctxSyncPulse)
    `CHK("stall", 5 + int'(irqBusy), n)
    `CHK("call", op == 2'h2, sysCallTake)
    `CHK("ctx", ec, issueCtx)
    step(1);
    `CHK("hold", 1'b0, issueHold)
  endtask

  initial begin
    step(4);
    rst <= 1'b0;
    step(1);
    rd(ECS_OFF_CTRL, ECS_RESP_OKAY, ECS_CTRL_RESET);
    `CHK("pc", ECS_PC_RESET, fetchPc)
    wr(ECS_OFF_CTRL, 32'hFFFF_FFFF, ECS_RESP_OKAY);
    rd(ECS_OFF_CTRL, ECS_RESP_OKAY, ECS_CTRL_MASK);
    rd(8'hF0, ECS_RESP_SLVERR, 32'h0);
    wr(ECS_OFF_EA, 32'h1, ECS_RESP_SLVERR);
    wr(ECS_OFF_SYNC, 32'h50, ECS_RESP_SLVERR);
    $display("test reset done");
    wr(ECS_OFF_CTRL, 32'h200, ECS_RESP_OKAY);
    wr(ECS_OFF_BASE, 32'hFFFF_FFF0, ECS_RESP_OKAY);
    wr(ECS_OFF_DISP, 32'h20, ECS_RESP_OKAY);
    step(2);
    `CHK("ea disp", 32'h10, dataEa)
    `CHK("aligned", 1'b1, eaAligned)
    wr(ECS_OFF_INDEX, 32'h3, ECS_RESP_OKAY);
    wr(ECS_OFF_CTRL, 32'h408, ECS_RESP_OKAY); // 16-byte operand runs past the top
    step(2);
    `CHK("ea index", 32'hFFFF_FFF3, dataEa)
    `CHK("misaligned", 1'b0, eaAligned)
    `CHK("wraps", 1'b1, eaWraps)
    rd(ECS_OFF_LANES, ECS_RESP_OKAY, 32'hFFF3_0002);
    wr(ECS_OFF_CTRL, 32'h218, ECS_RESP_OKAY);
    step(2);
    `CHK("ea base zero", 32'h3, dataEa)
    rd(ECS_OFF_EA, ECS_RESP_OKAY, 32'h3);
    rd(ECS_OFF_LANES, ECS_RESP_OKAY, 32'h0003_0006);
    wr(ECS_OFF_CTRL, 32'h219, ECS_RESP_OKAY);
    rd(ECS_OFF_LANES, ECS_RESP_OKAY, 32'h0006_0003);
    $display("test effective address done");
    wr(ECS_OFF_LINK, 32'h1237, ECS_RESP_OKAY);
    wr(ECS_OFF_COUNT, 32'h8000_000B, ECS_RESP_OKAY);
    wr(ECS_OFF_CTRL, 32'h020, ECS_RESP_OKAY);
    rd(ECS_OFF_TARGET, ECS_RESP_OKAY, 32'h1234);
    wr(ECS_OFF_CTRL, 32'h040, ECS_RESP_OKAY);
    rd(ECS_OFF_TARGET, ECS_RESP_OKAY, 32'h8000_0008);
    wr(ECS_OFF_DISP, 32'h100, ECS_RESP_OKAY);
    wr(ECS_OFF_CTRL, 32'h082, ECS_RESP_OKAY);
    step(2);
    `CHK("target imm", 32'h100, branchTarget)
    branch();
    `CHK("pc taken", 32'h100, fetchPc)
    branch();
    rd(ECS_OFF_STATUS, ECS_RESP_OKAY, 32'h0000_0301);
    wr(ECS_OFF_PC, 32'hFFFF_FFFC, ECS_RESP_OKAY);
    fetchAdvance <= 1'b1;
    step(1);
    fetchAdvance <= 1'b0;
    step(2);
    `CHK("pc wrap", 32'h0, fetchPc)
    $display("test branch target done");
    sync(2'h2, 3'h5, 3'h5);
    irqBusy <= 1'b1;
    sync(2'h2, 3'h6, 3'h6);
    irqBusy <= 1'b0;
    sync(2'h3, 3'h2, 3'h2);
    sync(2'h1, 3'h7, 3'h2);
    // History clear after disable and a sync, then a branch
    wr(ECS_OFF_CTRL, 32'h080, ECS_RESP_OKAY);
    sync(2'h1, 3'h0, 3'h2);
    wr(ECS_OFF_CTRL, 32'h084, ECS_RESP_OKAY);
    branchResolved <= 1'b1;
    branchTaken <= 1'b0;
    step(1);
    branchResolved <= 1'b0;
    step(2);
    `CHK("history", 8'h00, branchHistory)
    $display("test context sync done");
    for (int k = 1; k < 4; k++) begin
      asyncIrqKind <= k[1:0];
      asyncIrq <= 1'b1;
      step(1);
      asyncIrq <= 1'b0;
      seen = 1'b0;
      repeat (6) begin
        @(posedge core_clk);
        seen = seen | ctxSyncPulse;
      end
      `CHK("irq sync", k == 3, seen)
    end
    $display("test async interrupts done");
    end_sim();
  end
endmodule // ecs_ea_gen_context_sync_tb_top
